// ==== rtl/adcsq_top.sv ====
// Serial command decoder and conversion-mode sequencer of the converter.
// Assumes host pins are asynchronous and SCLK is far slower than CLOCK
// (at least 6 CLOCK periods per SCLK period); ADC_RESULT is same-clock logic.
// Function
// - Sweep: one conversion per trigger along the sequence until the threshold, one interrupt
// - Repeat sweep continues; unread FIFO gets cleared
// - Extended sampling: start pin triggers, chip select high
// - Normal sweep: chip select or sync triggers
// - End-of-conversion selection honoured in single-shot only
// - Read config: decode 4 clocks, then shift out
// - First command after interrupt outputs first FIFO word
// - Non-read first command stops output, keeps word except in repeat sweep, which clears the FIFO
// - Read cycles never convert nor signal
// - FIFO reads paced by serial clock, pausable
// - Write loads 12-bit config, no conversion
// - Single-shot extended: start pin rising edge converts
// - Launch and capture on rising serial clock
// - Every config write clears the FIFO
// - Eight-entry FIFO, interrupt at programmable threshold
// - Conversion takes 14 serial-derived clocks
`timescale 1ns/1ps
module adcsq_top
    import adcsq_pkg::*;
(
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CS_N,
    input wire logic FRAME_SYNC_IN,
    input wire logic SCLK,
    input wire logic SDI,
    input wire logic CONVERSION_START_PIN_N,
    input wire logic [adcsq_pkg::RES_W-1:0] ADC_RESULT,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OUT_OE,
    output logic INT_EOC_N,
    output logic CONV_START,
    output logic [adcsq_pkg::CHAN_W-1:0] CONV_CHANNEL,
    output logic CONV_BUSY
);
    import adcsq_pkg::*;

    // Whole state of the sequencer.
    typedef struct packed {
        adcsq_frame_e fr; // Frame phase.
        logic [4:0] bitcnt; // Serial clocks seen in this word.
        logic [WORD_W-1:0] sh_in; // Bits captured from SDI.
        logic [WORD_W-1:0] sh_out; // Bits still to send.
        logic [3:0] cmd; // Decoded command of this frame.
        logic first_word; // Frame opened with the FIFO head on the line.
        logic [1:0] reload; // Delay line until the next FIFO word is shown.
        logic cs_q; // Previous synchronised pin levels for edge detection.
        logic fs_q;
        logic sclk_q;
        logic cst_q;
        logic [CFG_W-1:0] config_register; // Programmed configuration.
        adcsq_conv_e cv; // Converter phase.
        logic [3:0] ccnt; // Conversion clocks counted.
        logic div_ph; // Divide-by-two phase.
        logic [1:0] seq_idx; // Step in the sweep sequence.
        logic [CHAN_W-1:0] sel_chan; // Channel chosen by a select command.
        logic armed; // A select command enables triggered conversions.
        logic sweep_done; // Single sweep finished, waiting for a write.
        logic int_pend; // Threshold interrupt awaits service.
        logic [RES_W-1:0] result; // Last single-shot result.
        logic push; // FIFO push strobe.
        logic pop; // FIFO pop strobe.
        logic clr; // FIFO clear strobe.
        logic [WORD_W-1:0] push_data;
        logic serial_data_out;
        logic sdo_oe;
        logic irq_n;
        logic conv_start;
        logic [CHAN_W-1:0] conv_chan;
        logic busy;
    } adcsq_state_s;

    adcsq_state_s s_ff;
    adcsq_state_s nxt_s;
    logic cs_n_s, fs_s, sclk_s, sdi_s, cst_n_s;
    logic sclk_rise, cs_rise, frame_start, cst_rise;
    adcsq_mode_e mode;
    logic ext, eoc_mode, div2;
    logic [3:0] cmd_now;
    logic [WORD_W-1:0] word_now;
    logic is_sel, is_ctl, trig, allow, wr_now;

    adcsq_fifo_if #(.WIDTH(WORD_W), .DEPTH(RES_DEPTH)) fifo_bus ();

    // Every host pin passes two flip-flops before any logic sees it.
    adcsq_sync #(.W(5), .INIT(5'h11)) u_sync (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .d({CS_N, FRAME_SYNC_IN, SCLK, SDI, CONVERSION_START_PIN_N}),
        .q({cs_n_s, fs_s, sclk_s, sdi_s, cst_n_s})
    );

    // Eight result words; a full FIFO refuses new conversion starts.
    adcsq_fifo #(.WIDTH(WORD_W), .DEPTH(RES_DEPTH)) u_fifo (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .port(fifo_bus)
    );

    assign fifo_bus.clear = s_ff.clr;
    assign fifo_bus.in_valid = s_ff.push;
    assign fifo_bus.in_data = s_ff.push_data;
    assign fifo_bus.out_ready = s_ff.pop;

    // Edges and configuration fields.
    always_comb begin
        sclk_rise = sclk_s && !s_ff.sclk_q;
        cs_rise = cs_n_s && !s_ff.cs_q;
        frame_start = (s_ff.cs_q && !cs_n_s) || (!cs_n_s && fs_s && !s_ff.fs_q);
        cst_rise = cst_n_s && !s_ff.cst_q;
        mode = adcsq_mode_e'(s_ff.config_register[MODE_LSB +: 2]);
        ext = s_ff.config_register[EXT_BIT];
        div2 = s_ff.config_register[DIV_BIT];
        // End-of-conversion style only counts in single-shot mode.
        eoc_mode = (mode == MODE_SINGLE) && s_ff.config_register[EOC_BIT];
        cmd_now = {s_ff.sh_in[2:0], sdi_s};
        word_now = {s_ff.sh_in[WORD_W-2:0], sdi_s};
        is_sel = (cmd_now <= CMD_SEL_LAST);
        is_ctl = (cmd_now == CMD_RD_CFG) || (cmd_now == CMD_WR_CFG)
            || (cmd_now == CMD_RD_FIFO);
    end

    // Next-state logic: frame decode, trigger, conversion, then writes.
    always_comb begin
        nxt_s = s_ff;
        trig = 1'b0;
        allow = 1'b0;
        wr_now = 1'b0;
        nxt_s.push = 1'b0;
        nxt_s.pop = 1'b0;
        nxt_s.clr = 1'b0;
        nxt_s.conv_start = 1'b0;
        nxt_s.cs_q = cs_n_s;
        nxt_s.fs_q = fs_s;
        nxt_s.sclk_q = sclk_s;
        nxt_s.cst_q = cst_n_s;
        nxt_s.reload = {s_ff.reload[0], 1'b0};

        // Which modes may start a conversion now.
        unique case (mode)
            MODE_SINGLE: allow = s_ff.armed;
            MODE_REPEAT: allow = s_ff.armed;
            MODE_SWEEP: allow = !s_ff.sweep_done;
            MODE_RSWEEP: allow = 1'b1;
        endcase

        if (cs_rise) begin
            // Chip select high ends any frame and releases the line.
            nxt_s.fr = FR_IDLE;
            nxt_s.sdo_oe = 1'b0;
        end else if (frame_start) begin
            // With an interrupt pending, the head word goes out before the command is known.
            nxt_s.fr = FR_CMD;
            nxt_s.bitcnt = '0;
            nxt_s.sdo_oe = 1'b1;
            nxt_s.first_word = s_ff.int_pend && fifo_bus.out_valid
                && (mode != MODE_SINGLE);
            if (!eoc_mode) begin
                nxt_s.irq_n = 1'b1;
            end
            if (nxt_s.first_word) begin
                nxt_s.serial_data_out = fifo_bus.out_data[WORD_W-1];
                nxt_s.sh_out = {fifo_bus.out_data[WORD_W-2:0], 1'b0};
            end else begin
                // Single shot reads back the previous result here.
                nxt_s.serial_data_out = s_ff.result[RES_W-1];
                nxt_s.sh_out = {s_ff.result[RES_W-2:0], 7'h00};
            end
        end else if (s_ff.fr != FR_IDLE && sclk_rise) begin
            // Capture and launch both happen on the rising serial clock.
            nxt_s.sh_in = word_now;
            nxt_s.serial_data_out = s_ff.sh_out[WORD_W-1];
            nxt_s.sh_out = {s_ff.sh_out[WORD_W-2:0], 1'b0};
            nxt_s.bitcnt = s_ff.bitcnt + 5'h01;
            if (s_ff.fr == FR_CMD && s_ff.bitcnt == CMD_BITS - 5'h01) begin
                // Command decode at the fourth serial clock.
                nxt_s.fr = FR_DATA;
                nxt_s.cmd = cmd_now;
                if (s_ff.first_word && cmd_now != CMD_RD_FIFO) begin
                    // Output stops; the head word stays for a later read, except in repeat sweep, which clears the FIFO.
                    nxt_s.sdo_oe = 1'b0;
                    if (mode == MODE_RSWEEP) begin
                        nxt_s.clr = 1'b1;
                        nxt_s.int_pend = 1'b0;
                    end
                end
                if (cmd_now == CMD_RD_FIFO && !s_ff.first_word) begin
                    nxt_s.sdo_oe = fifo_bus.out_valid;
                    nxt_s.serial_data_out = fifo_bus.out_data[WORD_W-1];
                    nxt_s.sh_out = {fifo_bus.out_data[WORD_W-2:0], 1'b0};
                end else if (cmd_now == CMD_RD_CFG) begin
                    // Configuration follows straight after the command.
                    nxt_s.sdo_oe = 1'b1;
                    nxt_s.serial_data_out = s_ff.config_register[CFG_W-1];
                    nxt_s.sh_out = {s_ff.config_register[CFG_W-2:0], 5'h00};
                end else if (cmd_now == CMD_WR_CFG) begin
                    nxt_s.sdo_oe = 1'b0;
                end else if (!is_ctl) begin
                    // Only single shot returns data in a trigger frame.
                    nxt_s.sdo_oe = s_ff.sdo_oe && (mode == MODE_SINGLE);
                    if (is_sel && (mode == MODE_SINGLE || mode == MODE_REPEAT)) begin
                        nxt_s.sel_chan = cmd_now[CHAN_W-1:0];
                        nxt_s.armed = 1'b1;
                    end
                    // Normal sampling starts on the frame itself; read and
                    // write frames never get here.
                    if (!ext) begin
                        trig = (mode == MODE_SINGLE) ? is_sel
                            : (mode == MODE_REPEAT) ? (is_sel || s_ff.armed)
                            : allow;
                    end
                end
            end else if (s_ff.fr == FR_DATA && s_ff.bitcnt == FRAME_BITS - 5'h01) begin
                nxt_s.bitcnt = '0;
                if (s_ff.cmd == CMD_WR_CFG) begin
                    wr_now = 1'b1;
                    nxt_s.fr = FR_IDLE;
                end else if (s_ff.cmd == CMD_RD_FIFO && s_ff.sdo_oe) begin
                    // Word done: pop and stay ready for the next 16 clocks;
                    // nothing advances while the serial clock pauses.
                    nxt_s.pop = 1'b1;
                    nxt_s.reload = 2'b01;
                end else begin
                    nxt_s.fr = FR_IDLE;
                    nxt_s.sdo_oe = 1'b0;
                end
            end
        end

        // Two cycles after a pop the new head word is valid.
        if (s_ff.reload[1]) begin
            if (fifo_bus.out_valid) begin
                nxt_s.serial_data_out = fifo_bus.out_data[WORD_W-1];
                nxt_s.sh_out = {fifo_bus.out_data[WORD_W-2:0], 1'b0};
            end else begin
                nxt_s.sdo_oe = 1'b0;
                nxt_s.int_pend = 1'b0;
            end
        end

        // The start pin triggers only while chip select is high.
        if (ext && cst_rise && cs_n_s && allow) begin
            trig = 1'b1;
        end

        // Conversion start; a busy converter or full FIFO refuses it.
        if (trig && s_ff.cv == CV_IDLE && fifo_bus.in_ready) begin
            nxt_s.cv = CV_RUN;
            nxt_s.ccnt = '0;
            nxt_s.div_ph = 1'b0;
            nxt_s.busy = 1'b1;
            nxt_s.conv_start = 1'b1;
            nxt_s.conv_chan = (mode[1]) ? SWEEP_SEQ[s_ff.config_register[SEQ_LSB +: 2]][s_ff.seq_idx]
                : nxt_s.sel_chan;
            if (mode == MODE_SINGLE) begin
                nxt_s.armed = 1'b0;
            end
            if (mode == MODE_RSWEEP && s_ff.int_pend) begin
                // New trigger with unread data: discard the old contents.
                nxt_s.clr = 1'b1;
                nxt_s.int_pend = 1'b0;
            end
            if (eoc_mode) begin
                nxt_s.irq_n = 1'b0;
            end
        end

        // Conversion clock is the serial clock, optionally halved.
        if (s_ff.cv == CV_RUN && sclk_rise) begin
            nxt_s.div_ph = !s_ff.div_ph;
            if (!div2 || s_ff.div_ph) begin
                nxt_s.ccnt = s_ff.ccnt + 4'h1;
                if (s_ff.ccnt == CONV_CLKS - 4'h1) begin
                    nxt_s.cv = CV_IDLE;
                    nxt_s.busy = 1'b0;
                    if (mode == MODE_SINGLE) begin
                        nxt_s.result = ADC_RESULT;
                        nxt_s.irq_n = eoc_mode;
                    end else begin
                        nxt_s.push = 1'b1;
                        nxt_s.push_data = {{(WORD_W - RES_W){1'b0}}, ADC_RESULT};
                        nxt_s.seq_idx = s_ff.seq_idx + 2'h1;
                        if (!s_ff.int_pend && (fifo_bus.level + 4'h1)
                                >= thr_count(s_ff.config_register[THR_LSB +: 2])) begin
                            nxt_s.int_pend = 1'b1;
                            nxt_s.irq_n = 1'b0;
                            nxt_s.sweep_done = (mode == MODE_SWEEP);
                            nxt_s.armed = !(mode == MODE_REPEAT) && s_ff.armed;
                        end
                    end
                end
            end
        end

        // A configuration write overrides everything and empties the FIFO.
        if (wr_now) begin
            nxt_s.config_register = word_now[CFG_W-1:0];
            nxt_s.clr = 1'b1;
            nxt_s.push = 1'b0;
            nxt_s.int_pend = 1'b0;
            nxt_s.armed = 1'b0;
            nxt_s.sweep_done = 1'b0;
            nxt_s.seq_idx = '0;
            nxt_s.cv = CV_IDLE;
            nxt_s.busy = 1'b0;
            nxt_s.irq_n = 1'b1;
        end
    end

    // State register; the edge history starts at the idle pin levels.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_ff <= '0;
            s_ff.config_register <= CFG_RESET;
            s_ff.cs_q <= 1'b1;
            s_ff.cst_q <= 1'b1;
            s_ff.irq_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register.
    assign SERIAL_DATA_OUT = s_ff.serial_data_out;
    assign SERIAL_DATA_OUT_OE = s_ff.sdo_oe;
    assign INT_EOC_N = s_ff.irq_n;
    assign CONV_START = s_ff.conv_start;
    assign CONV_CHANNEL = s_ff.conv_chan;
    assign CONV_BUSY = s_ff.busy;
endmodule

// ==== rtl/adcsq_pkg.sv ====
// Shared constants and types of the serial command decoder and mode sequencer.
// Assumes a single 25 MHz clock; every host pin is synchronised before use.
package adcsq_pkg;

    // Serial framing: a frame is 16 serial clocks, the first 4 carry the command.
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CMD_BITS = 5'h04;
    localparam int WORD_W = 16;
    localparam int CFG_W = 12;
    localparam int RES_W = 10;
    localparam int CHAN_W = 3;

    // A conversion takes 14 conversion clocks.
    localparam logic [3:0] CONV_CLKS = 4'he;

    // Result FIFO depth used by the block.
    localparam int RES_DEPTH = 8;

    // Command codes in the top 4 bits of a frame; 0 to 7 select a channel.
    localparam logic [3:0] CMD_SEL_LAST = 4'h7;
    localparam logic [3:0] CMD_RD_CFG = 4'h9;
    localparam logic [3:0] CMD_WR_CFG = 4'ha;
    localparam logic [3:0] CMD_RD_FIFO = 4'he;

    // Field positions in the 12-bit configuration register.
    localparam int THR_LSB = 0;
    localparam int SEQ_LSB = 2;
    localparam int EXT_BIT = 4;
    localparam int MODE_LSB = 5;
    localparam int EOC_BIT = 7;
    localparam int DIV_BIT = 8;
    localparam logic [11:0] CFG_RESET = 12'h000;

    // Conversion modes held in the two mode bits.
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_REPEAT = 2'b01,
        MODE_SWEEP = 2'b10,
        MODE_RSWEEP = 2'b11
    } adcsq_mode_e;

    // Frame states, Gray coded along idle, command, data.
    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_CMD = 2'b01,
        FR_DATA = 2'b11
    } adcsq_frame_e;

    // Converter states.
    typedef enum logic {
        CV_IDLE = 1'b0,
        CV_RUN = 1'b1
    } adcsq_conv_e;

    // Sweep sequences, element [sel][step]: 0-1-2-3, 0-2-4-6, 4-5-6-7, 1-3-5-7.
    localparam logic [3:0][3:0][2:0] SWEEP_SEQ = '{
        '{3'h7, 3'h5, 3'h3, 3'h1},
        '{3'h7, 3'h6, 3'h5, 3'h4},
        '{3'h6, 3'h4, 3'h2, 3'h0},
        '{3'h3, 3'h2, 3'h1, 3'h0}
    };

    // Threshold code 0..3 stands for 2, 4, 6 or 8 stored results.
    function automatic logic [3:0] thr_count(input logic [1:0] code);
        thr_count = {1'b0, code, 1'b0} + 4'h2;
    endfunction

endpackage

// ==== rtl/adcsq_fifo_if.sv ====
// Carrier between the sequencer and its result FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface adcsq_fifo_if #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
);
    localparam int LW = $clog2(DEPTH + 1);
    logic clear; // Empties the FIFO in one cycle.
    logic in_valid; // Filling side offers a word.
    logic in_ready; // FIFO has room.
    logic [WIDTH-1:0] in_data;
    logic out_valid; // A word waits at the head.
    logic out_ready; // Draining side takes the head word.
    logic [WIDTH-1:0] out_data;
    logic [LW-1:0] level; // Words stored.

    modport fifo (input clear, in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data, level);
    modport user (output clear, in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data, level);
endinterface

// ==== rtl/adcsq_sync.sv ====
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes inputs are independent levels; only the second stage is read.
`timescale 1ns/1ps
module adcsq_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1; // First stage, read by the second stage only.
        logic [W-1:0] s2; // Settled copy.
    } adcsq_sync_s;

    adcsq_sync_s s_ff;
    adcsq_sync_s nxt_s;

    // Next state: shift the pins through both stages.
    always_comb begin
        nxt_s.s1 = d;
        nxt_s.s2 = s_ff.s1;
    end

    // Both stages reset to the idle level of the pins.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= {INIT, INIT};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.s2;
endmodule

// ==== rtl/adcsq_fifo.sv ====
// Synchronous result FIFO with registered head word and one-cycle clear.
// Assumes one clock; pushing while full or popping while empty is ignored.
`timescale 1ns/1ps
module adcsq_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    adcsq_fifo_if.fifo port
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [LW-1:0] FULL = LW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage.
        logic [AW-1:0] wptr; // Next slot to write.
        logic [AW-1:0] rptr; // Head slot.
        logic [LW-1:0] level; // Words stored.
        logic [WIDTH-1:0] head; // Registered copy of the head word.
    } adcsq_fifo_s;

    adcsq_fifo_s s_ff;
    adcsq_fifo_s nxt_s;
    logic do_push;
    logic do_pop;

    // Next state; the head register is fed from the next memory image so a
    // word pushed into an empty FIFO shows up one cycle later.
    always_comb begin
        nxt_s = s_ff;
        do_push = port.in_valid && (s_ff.level != FULL);
        do_pop = port.out_ready && (s_ff.level != '0);
        if (port.clear) begin
            // Clear wins over both push and pop.
            nxt_s.wptr = '0;
            nxt_s.rptr = '0;
            nxt_s.level = '0;
        end else begin
            if (do_push) begin
                nxt_s.mem[s_ff.wptr] = port.in_data;
                nxt_s.wptr = (s_ff.wptr == LAST) ? '0 : s_ff.wptr + 1'b1;
            end
            if (do_pop) begin
                nxt_s.rptr = (s_ff.rptr == LAST) ? '0 : s_ff.rptr + 1'b1;
            end
            nxt_s.level = s_ff.level + LW'(do_push) - LW'(do_pop);
        end
        nxt_s.head = nxt_s.mem[nxt_s.rptr];
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign port.in_ready = (s_ff.level != FULL);
    assign port.out_valid = (s_ff.level != '0);
    assign port.out_data = s_ff.head;
    assign port.level = s_ff.level;
endmodule

// ==== tb/adcsq_chk.sv ====
// Port-level assertions on the converter sequencer.
// Assumes one CLOCK domain; bound to the top by the statement after the module.
`timescale 1ns/1ps
module adcsq_chk (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CS_N,
    input wire logic SERIAL_DATA_OUT_OE,
    input wire logic INT_EOC_N,
    input wire logic CONV_START,
    input wire logic [adcsq_pkg::CHAN_W-1:0] CONV_CHANNEL,
    input wire logic CONV_BUSY
);
    // Every check shares the one clock and is idle in reset.
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);
    chk_start_busy: assert property (CONV_START |-> CONV_BUSY)
        else $error("start without busy");
    chk_start_pulse: assert property (CONV_START |=> !CONV_START)
        else $error("start longer than one cycle");
    chk_start_idle: assert property (CONV_START |-> !$past(CONV_BUSY))
        else $error("start while converting");
    chk_busy_min: assert property ($rose(CONV_BUSY) |-> CONV_BUSY [*8])
        else $error("conversion too short");
    chk_chan_hold: assert property (CONV_BUSY && !CONV_START |-> $stable(CONV_CHANNEL))
        else $error("channel moved mid conversion");
    chk_int_src: assert property ($fell(INT_EOC_N) |-> CONV_START || $fell(CONV_BUSY))
        else $error("status fell without conversion");
    chk_oe_idle: assert property (CS_N [*6] |-> !SERIAL_DATA_OUT_OE)
        else $error("output driven while deselected");
    chk_oe_frame: assert property ($rose(SERIAL_DATA_OUT_OE) |-> !$past(CS_N, 2))
        else $error("output raised outside a frame");
endmodule
bind adcsq_top adcsq_chk i_chk (.CLOCK(CLOCK), .ARST_N(ARST_N), .CS_N(CS_N),
    .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE), .INT_EOC_N(INT_EOC_N),
    .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL), .CONV_BUSY(CONV_BUSY));

// ==== tb/adcsq_host.sv ====
// Host serial port model: select, serial clock, data and conversion start pin.
// Assumes the bench clock; every pin changes at its falling edge.
`timescale 1ns/1ps
module adcsq_host (
    input wire logic clk,
    input wire logic serial_data_out,
    output logic cs_n = 1'b1,
    output logic sclk = 1'b0,
    output logic sdi = 1'b1,
    output logic st_n = 1'b1
);
    // SCLK periods of eight bench clocks; the converter also runs on them.
    task automatic run(input int n);
        repeat (n) begin
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
    endtask
    // One frame of nw copies of w, sampling output before each rise.
    task automatic xfer(input logic [15:0] w, input int nw, input logic st,
        output logic [63:0] r);
        r = '0;
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        st_n = ~st;
        for (int i = 0; i < 16 * nw; i++) begin
            sdi = w[15 - i % 16];
            r = {r[62:0], serial_data_out};
            run(1);
            if (i % 16 == 15) repeat (8) @(negedge clk);
        end
        cs_n = 1'b1;
        sdi = ~sdi; // A released line must not keep showing the last bit.
        repeat (8) @(negedge clk);
        st_n = 1'b1;
        run(18);
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the converter sequencer, driven by the host model.
// Assumes the checker binds itself; the analog core is modelled below.
`timescale 1ns/1ps
module tb_top;
    import adcsq_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, cs_n, sclk, sdi, st_n, serial_data_out, oe, int_n, conversion_start_pin, busy;
    logic [CHAN_W-1:0] chan, chs[$]; // Channels logged in start order.
    logic [RES_W-1:0] adc = '0; // A fixed tag plus the channel, so words name their source.
    logic [63:0] r;
    int error_cnt = 0, checks = 0, cyc = 0, eoc_seen = 0;
    // A released output reads back inverted, so a bit taken with the enable low shows up.
    adcsq_host i_host (.clk(clk), .serial_data_out(oe ? serial_data_out : !serial_data_out), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .st_n(st_n));
    adcsq_top i_dut (.CLOCK(clk), .ARST_N(arst_n), .CS_N(cs_n), .FRAME_SYNC_IN(1'b1),
        .SCLK(sclk), .SDI(sdi), .CONVERSION_START_PIN_N(st_n), .ADC_RESULT(adc),
        .SERIAL_DATA_OUT(serial_data_out), .SERIAL_DATA_OUT_OE(oe), .INT_EOC_N(int_n),
        .CONV_START(conversion_start_pin), .CONV_CHANNEL(chan), .CONV_BUSY(busy));
    // Free-running 25 MHz clock.
    initial begin
        forever #20 clk = ~clk;
    end
    // Core model, start log, status watch and hang limit, all off the sampling edge.
    always @(negedge clk) begin
        adc <= {7'h54, chan};
        if (conversion_start_pin === 1'b1) chs.push_back(chan);
        if (busy === 1'b1 && int_n !== 1'b1) eoc_seen++;
        cyc++;
        if (cyc == 20000) error_cnt++;
        if (cyc == 20000) test_done();
    end
    // Count every comparison and report a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) error_cnt++;
        if (seen !== exp) $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    endtask
    // Counts, verdict and the end of the run.
    task automatic test_done();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One host frame of nw words without the start pin.
    task automatic xf(input logic [15:0] w, input int nw);
        i_host.xfer(w, nw, 1'b0, r);
    endtask
    // Reset for 12 cycles, then sweep, repeat sweep, repeat and extended single shot.
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        xf({CMD_RD_CFG, 12'h000}, 1);
        check({4'h0, r[11:0]}, {4'h0, CFG_RESET});
        xf({CMD_WR_CFG, 12'h0c1}, 1); // Sweep, end-of-conversion chosen, four results.
        xf({CMD_RD_CFG, 12'h000}, 1);
        check({4'h0, r[11:0]}, 16'h00c1);
        check(16'(chs.size()), 16'h0000);
        repeat (4) xf(16'hf000, 1);
        check({15'h0, int_n}, 16'h0000);
        for (int i = 0; i < 4; i++) check({13'h0, chs[i]}, 16'(i));
        xf({CMD_RD_CFG, 12'h000}, 1); // Not a FIFO read, so the head word must survive.
        xf({CMD_RD_FIFO, 12'h000}, 4);
        for (int k = 0; k < 4; k++) check(r[63 - 16 * k -: 16], 16'h02a0 + 16'(k));
        check(16'(chs.size()), 16'h0004);
        check(16'(eoc_seen), 16'h0000);
        xf({CMD_WR_CFG, 12'h060}, 1);
        chs.delete();
        repeat (4) xf(16'hf000, 1);
        xf({CMD_RD_FIFO, 12'h000}, 2);
        check(r[31:16], 16'h02a2);
        check(r[15:0], 16'h02a3);
        repeat (2) xf(16'hf000, 1);
        for (int i = 0; i < 6; i++) check({13'h0, chs[i]}, 16'(i % 4));
        xf({CMD_WR_CFG, 12'h020}, 1); // Repeat mode, threshold two: mode write, then select.
        chs.delete();
        xf(16'h3000, 1);
        repeat (2) xf(16'hf000, 1); // The second trigger comes unselected; its interrupt disarms the third.
        check(16'(chs.size()), 16'h0002);
        check({13'h0, chs[1]}, 16'h0003);
        xf({CMD_RD_FIFO, 12'h000}, 2);
        check(r[31:16], 16'h02a3);
        check(r[15:0], 16'h02a3);
        xf({CMD_WR_CFG, 12'h090}, 1); // Single shot, extended sampling, end-of-conversion style.
        chs.delete();
        eoc_seen = 0;
        i_host.xfer(16'h5000, 1, 1'b1, r);
        check(16'(chs.size()), 16'h0001);
        check({13'h0, chs[0]}, 16'h0005);
        // Status stays low for at least 13 serial clock periods of eight clocks each.
        check({15'h0, eoc_seen >= 104}, 16'h0001);
        test_done();
    end
endmodule
